// ==== core/dar_pkg.sv ====
// Package for the amplitude, multichip sync and ramp register slice.
// Assumes one system clock domain; serial port pins are synchronised in the core.
package dar_pkg;
    // Register addresses on the serial port
    localparam int          ADDR_W     = 5;
    localparam logic [4:0]  ADDR_AMP   = 5'h09;
    localparam logic [4:0]  ADDR_SYNC  = 5'h0a;
    localparam logic [4:0]  ADDR_LIM   = 5'h0b;
    localparam logic [4:0]  ADDR_STEP  = 5'h0c;
    localparam logic [4:0]  ADDR_RATE  = 5'h0d;
    // Instruction byte layout
    localparam int          INSTR_BITS = 8;
    localparam int          INSTR_RD   = 7;
    localparam int          BITS_WORD  = 32;
    localparam int          BITS_LONG  = 64;
    // Values after reset
    localparam logic [31:0] AMP_RST    = 32'h0000_0000;
    localparam logic [31:0] SYNC_RST   = 32'h0000_0000;
    localparam logic [63:0] LIM_RST    = 64'h0;
    localparam logic [63:0] STEP_RST   = 64'h0;
    localparam logic [31:0] RATE_RST   = 32'h0000_0000;
    // Open bits of the sync register read as zero
    localparam logic [31:0] SYNC_WMASK = 32'hfefc_f8f8;
    // Amplitude register fields
    localparam int          AMP_RR_LSB = 16;
    localparam int          AMP_SF_LSB = 2;
    localparam int          AMP_SS_LSB = 0;
    localparam logic [1:0]  KEY_AUTO   = 2'h3;
    // Sync register fields
    localparam int          SYN_VD_LSB = 28;
    localparam int          SYN_RX_BIT = 27;
    localparam int          SYN_GE_BIT = 26;
    localparam int          SYN_GP_BIT = 25;
    localparam int          SYN_PS_LSB = 18;
    localparam int          SYN_OD_LSB = 11;
    localparam int          SYN_ID_LSB = 3;
    // Ramp register fields
    localparam int          HI_LSB     = 32;
    localparam int          LO_LSB     = 0;
    localparam int          RATE_N_LSB = 16;
    localparam int          RATE_P_LSB = 0;

    // Output keying settings
    typedef struct packed {
        logic [15:0] ramp_rate;
        logic [13:0] scale;
        logic [1:0]  step;
    } dar_amp_t;

    // Multichip sync settings
    typedef struct packed {
        logic [3:0] valid_delay;
        logic       rx_enable;
        logic       gen_enable;
        logic       gen_falling;
        logic [5:0] preset;
        logic [4:0] out_delay;
        logic [4:0] in_delay;
    } dar_sync_t;

    // Ramp generator settings
    typedef struct packed {
        logic [31:0] upper;
        logic [31:0] lower;
        logic [31:0] dec_step;
        logic [31:0] inc_step;
        logic [15:0] neg_rate;
        logic [15:0] pos_rate;
    } dar_ramp_t;
endpackage

// ==== core/dar_regs.sv ====
// Serially programmed register slice: amplitude scale, multichip sync, ramp limits,
// ramp steps and ramp rates, staged and applied on an update pulse.
// Assumes serial pins and the update pin arrive asynchronously and toggle much
// slower than the system clock; keying mode and ramp enable come from same-clock logic.
// Operation
// - Amplitude register 32 bits; scale factor in bits 15:2 drives amplitude.
// - Amplitude ramp rate and step size act only in keying mode 11b.
// - Sync bits 31:28 give 4-bit validation skew, reset 0000b.
// - Sync bit 27 enables sync receiver, cleared at reset.
// - Sync bit 26 enables sync generator, cleared at reset.
// - Sync bit 25 picks rising (0) or falling (1) edge alignment.
// - Sync bits 23:18 hold 6-bit preset state, reset zero.
// - Sync bits 15:11 give 5-bit generator output delay, reset zero.
// - Sync bits 7:3 give 5-bit receiver input delay, reset zero.
// - Ramp limit register 64 bits: upper in 63:32, lower in 31:0.
// - Ramp step register 64 bits: decrement 63:32, increment 31:0.
// - Limit, step and rate registers act only with ramp enable set.
// - Ramp rate register is 32 bits at address 0x0D.
// - Ramp rate holds negative interval 31:16 and positive interval 15:0.
module dar_regs
    import dar_pkg::*;
(
    input  wire logic       i_mclk,
    input  wire logic       i_resetn,
    input  wire logic       i_sclk,
    input  wire logic       i_cs_n,
    input  wire logic       i_sdio,
    input  wire logic       i_io_update,
    input  wire logic [1:0] i_keying_mode,
    input  wire logic       i_ramp_enable,
    output logic            o_sdo,
    output logic            o_sdo_oe,
    output dar_amp_t        o_amp,
    output dar_sync_t       o_sync,
    output dar_ramp_t       o_ramp
);
    typedef enum logic [0:0] {S_INSTR, S_DATA} dar_state_t;

    // Number of data bits a register takes on the serial port
    function automatic logic [6:0] reg_bits(input logic [ADDR_W-1:0] a);
        reg_bits = (a == ADDR_LIM || a == ADDR_STEP) ? 7'(BITS_LONG) : 7'(BITS_WORD);
    endfunction

    logic              sclk_m, sclk_s, sclk_q;
    logic              csn_m, csn_s;
    logic              sdio_m, sdio_s;
    logic              upd_m, upd_s, upd_q;
    logic              sclk_rise, sclk_fall, upd_rise;
    dar_state_t        state;
    logic [5:0]        cnt;
    logic [63:0]       sh;
    logic [63:0]       tx;
    logic              rd;
    logic [ADDR_W-1:0] addr;
    logic [ADDR_W-1:0] next_addr;
    logic [63:0]       next_word;
    logic              instr_done, data_done, wr_commit;
    logic [63:0]       rd_val;
    logic [31:0]       stg_amp, stg_sync, stg_rate, act_amp, act_sync, act_rate;
    logic [63:0]       stg_lim, stg_step, act_lim, act_step;

    // Two-stage synchronisers for the serial and update pins
    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            sclk_m <= 1'b0;
            sclk_s <= 1'b0;
            sclk_q <= 1'b0;
            csn_m  <= 1'b1;
            csn_s  <= 1'b1;
            sdio_m <= 1'b0;
            sdio_s <= 1'b0;
            upd_m  <= 1'b0;
            upd_s  <= 1'b0;
            upd_q  <= 1'b0;
        end else begin
            sclk_m <= i_sclk;
            sclk_s <= sclk_m;
            sclk_q <= sclk_s;
            csn_m  <= i_cs_n;
            csn_s  <= csn_m;
            sdio_m <= i_sdio;
            sdio_s <= sdio_m;
            upd_m  <= i_io_update;
            upd_s  <= upd_m;
            upd_q  <= upd_s;
        end
    end

    // Edge events on the system clock
    assign sclk_rise  = sclk_s & ~sclk_q & ~csn_s;
    assign sclk_fall  = ~sclk_s & sclk_q & ~csn_s;
    assign upd_rise   = upd_s & ~upd_q;
    assign next_word  = {sh[62:0], sdio_s};
    assign next_addr  = next_word[ADDR_W-1:0];
    assign instr_done = sclk_rise && state == S_INSTR && cnt == 6'(INSTR_BITS - 1);
    assign data_done  = sclk_rise && state == S_DATA && cnt == 6'(reg_bits(addr) - 7'd1);
    assign wr_commit  = data_done && !rd;

    // Serial framing: instruction byte, then one register's data, then repeat
    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            state <= S_INSTR;
            cnt   <= 6'h0;
            sh    <= 64'h0;
            rd    <= 1'b0;
            addr  <= '0;
        end else if (csn_s) begin
            state <= S_INSTR;
            cnt   <= 6'h0;
        end else if (sclk_rise) begin
            sh <= next_word;
            case (state)
                S_INSTR: begin
                    if (instr_done) begin
                        rd    <= next_word[INSTR_RD];
                        addr  <= next_addr;
                        cnt   <= 6'h0;
                        state <= S_DATA;
                    end else begin
                        cnt <= cnt + 6'h1;
                    end
                end
                S_DATA: begin
                    if (data_done) begin
                        cnt   <= 6'h0;
                        state <= S_INSTR;
                    end else begin
                        cnt <= cnt + 6'h1;
                    end
                end
                default: state <= S_INSTR;
            endcase
        end
    end

    // Readback of staged values, left aligned; unmapped reads return zero
    always_comb begin
        case (next_addr)
            ADDR_AMP:  rd_val = {stg_amp, 32'h0};
            ADDR_SYNC: rd_val = {stg_sync, 32'h0};
            ADDR_LIM:  rd_val = stg_lim;
            ADDR_STEP: rd_val = stg_step;
            ADDR_RATE: rd_val = {stg_rate, 32'h0};
            default:   rd_val = 64'h0;
        endcase
    end

    // Read shifter; MSB stands through the first data bit, later falls shift
    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            tx <= 64'h0;
        end else if (instr_done) begin
            tx <= next_word[INSTR_RD] ? rd_val : 64'h0;
        end else if (sclk_fall && state == S_DATA && rd && cnt != 6'h0) begin
            tx <= {tx[62:0], 1'b0};
        end
    end

    // Serial data out driven only during a read data phase
    assign o_sdo    = tx[63];
    assign o_sdo_oe = ~csn_s && state == S_DATA && rd;

    // Staging registers written from the serial port
    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            stg_amp  <= AMP_RST;
            stg_sync <= SYNC_RST;
            stg_lim  <= LIM_RST;
            stg_step <= STEP_RST;
            stg_rate <= RATE_RST;
        end else if (wr_commit) begin
            case (addr)
                ADDR_AMP:  stg_amp  <= next_word[31:0];
                ADDR_SYNC: stg_sync <= next_word[31:0] & SYNC_WMASK;
                ADDR_LIM:  stg_lim  <= next_word;
                ADDR_STEP: stg_step <= next_word;
                ADDR_RATE: stg_rate <= next_word[31:0];
                default: ;
            endcase
        end
    end

    // All staged values move to the active set on one update edge
    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            act_amp  <= AMP_RST;
            act_sync <= SYNC_RST;
            act_lim  <= LIM_RST;
            act_step <= STEP_RST;
            act_rate <= RATE_RST;
        end else if (upd_rise) begin
            act_amp  <= stg_amp;
            act_sync <= stg_sync;
            act_lim  <= stg_lim;
            act_step <= stg_step;
            act_rate <= stg_rate;
        end
    end

    // Amplitude outputs; ramp rate and step held at zero outside automatic keying
    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_amp <= '0;
        end else begin
            o_amp.scale <= act_amp[AMP_SF_LSB +: 14];
            if (i_keying_mode == KEY_AUTO) begin
                o_amp.ramp_rate <= act_amp[AMP_RR_LSB +: 16];
                o_amp.step      <= act_amp[AMP_SS_LSB +: 2];
            end else begin
                o_amp.ramp_rate <= 16'h0;
                o_amp.step      <= 2'h0;
            end
        end
    end

    // Multichip sync outputs
    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_sync <= '0;
        end else begin
            o_sync.valid_delay <= act_sync[SYN_VD_LSB +: 4];
            o_sync.rx_enable   <= act_sync[SYN_RX_BIT];
            o_sync.gen_enable  <= act_sync[SYN_GE_BIT];
            o_sync.gen_falling <= act_sync[SYN_GP_BIT];
            o_sync.preset      <= act_sync[SYN_PS_LSB +: 6];
            o_sync.out_delay   <= act_sync[SYN_OD_LSB +: 5];
            o_sync.in_delay    <= act_sync[SYN_ID_LSB +: 5];
        end
    end

    // Ramp outputs, all zero while the ramp generator is disabled
    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_ramp <= '0;
        end else if (!i_ramp_enable) begin
            o_ramp <= '0;
        end else begin
            o_ramp.upper    <= act_lim[HI_LSB +: 32];
            o_ramp.lower    <= act_lim[LO_LSB +: 32];
            o_ramp.dec_step <= act_step[HI_LSB +: 32];
            o_ramp.inc_step <= act_step[LO_LSB +: 32];
            o_ramp.neg_rate <= act_rate[RATE_N_LSB +: 16];
            o_ramp.pos_rate <= act_rate[RATE_P_LSB +: 16];
        end
    end

    // Checks
    sequence s_rate_write;
        wr_commit && addr == ADDR_RATE;
    endsequence

    sequence s_update;
        upd_rise;
    endsequence

    a_amp_scale: assert property (@(posedge i_mclk) disable iff (!i_resetn)
        s_update ##1 1'b1 ##1 1'b1 |-> o_amp.scale == $past(stg_amp[15:2], 2))
        else $error("amplitude scale not taken from staged bits");

    a_keying_gate: assert property (@(posedge i_mclk) disable iff (!i_resetn)
        i_keying_mode != 2'h3 |=> o_amp.ramp_rate == 16'h0 && o_amp.step == 2'h0)
        else $error("keying fields leaked outside automatic mode");

    a_sync_fields: assert property (@(posedge i_mclk) disable iff (!i_resetn)
        1'b1 |=> o_sync == {$past(act_sync[31:25]), $past(act_sync[23:18]),
                            $past(act_sync[15:11]), $past(act_sync[7:3])})
        else $error("sync outputs do not follow active register");

    a_sync_open: assert property (@(posedge i_mclk) disable iff (!i_resetn)
        (stg_sync & ~SYNC_WMASK) == 32'h0)
        else $error("open sync bits stored");

    a_ramp_gate: assert property (@(posedge i_mclk) disable iff (!i_resetn)
        !i_ramp_enable |=> o_ramp == '0)
        else $error("ramp outputs active while disabled");

    a_limit_split: assert property (@(posedge i_mclk) disable iff (!i_resetn)
        i_ramp_enable |=> o_ramp.upper == $past(act_lim[63:32])
                          && o_ramp.lower == $past(act_lim[31:0]))
        else $error("ramp limit halves misplaced");

    a_rate_addr: assert property (@(posedge i_mclk) disable iff (!i_resetn)
        s_rate_write |=> stg_rate == $past(next_word[31:0]))
        else $error("ramp rate write lost");

    a_stage_hold: assert property (@(posedge i_mclk) disable iff (!i_resetn)
        !upd_rise |=> $stable(act_amp) && $stable(act_lim) && $stable(act_rate))
        else $error("active set changed without update");

    a_update_apply: assert property (@(posedge i_mclk) disable iff (!i_resetn)
        s_update |=> act_step == $past(stg_step) && act_sync == $past(stg_sync))
        else $error("update did not apply staged values");
endmodule

// ==== tb/dar_regs_test.sv ====
// Self-checking bench for the amplitude, sync and ramp register slice.
// Assumes the core samples the serial pins and the update pin through synchronisers.
module dar_regs_test;
    timeunit 1ns;
    timeprecision 1ps;
    import dar_pkg::*;

    localparam int LIMIT = 40000;
    logic        i_mclk        = 1'b0;
    logic        i_resetn      = 1'b0;
    logic        i_sclk        = 1'b0;
    logic        i_cs_n        = 1'b1;
    logic        i_sdio        = 1'b0;
    logic        i_io_update   = 1'b0;
    logic [1:0]  i_keying_mode = 2'h3;
    logic        i_ramp_enable = 1'b1;
    logic        o_sdo;
    logic        o_sdo_oe;
    dar_amp_t    o_amp;
    dar_sync_t   o_sync;
    dar_ramp_t   o_ramp;
    int          num_errors    = 0;
    int          n_compared    = 0;
    int          cycles        = 0;
    int          oe_hits       = 0;
    logic [63:0] rd;
    logic [31:0] wa            = 32'hbeef_a5a7;
    logic [63:0] wl            = 64'h0123_4567_89ab_cdef;
    logic [63:0] ws            = 64'hfedc_ba98_7654_3210;
    logic [31:0] wr            = 32'h1357_9bdf;
    logic [31:0] wsy [2]       = '{32'ha9d4_c8b8, 32'h5623_3747};

    dar_regs i_dut (
        .i_mclk        (i_mclk),
        .i_resetn      (i_resetn),
        .i_sclk        (i_sclk),
        .i_cs_n        (i_cs_n),
        .i_sdio        (i_sdio),
        .i_io_update   (i_io_update),
        .i_keying_mode (i_keying_mode),
        .i_ramp_enable (i_ramp_enable),
        .o_sdo         (o_sdo),
        .o_sdo_oe      (o_sdo_oe),
        .o_amp         (o_amp),
        .o_sync        (o_sync),
        .o_ramp        (o_ramp)
    );

    // System clock, 20 ns period
    always #10 i_mclk = ~i_mclk;

    // Hang guard
    always @(posedge i_mclk) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            num_errors++;
            wrap_up();
        end
    end

    task automatic tick(input int n);
        repeat (n) @(posedge i_mclk);
    endtask

    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // One serial bit: data set with clock low, read data taken before the rise
    task automatic sbit(input logic b, output logic r);
        i_sclk <= 1'b0;
        i_sdio <= b;
        tick(6);
        r = o_sdo;
        if (o_sdo_oe === 1'b1) oe_hits++;
        i_sclk <= 1'b1;
        tick(6);
    endtask

    // Whole frame: instruction byte then nb data bits, MSB first
    task automatic xfer(input logic [7:0] ins, input logic [63:0] wd, input int nb,
                        output logic [63:0] rdata);
        logic r;
        rdata = '0;
        i_cs_n <= 1'b0;
        tick(3);
        for (int i = 7; i >= 0; i--) sbit(ins[i], r);
        for (int i = nb - 1; i >= 0; i--) begin
            sbit(wd[i], r);
            rdata = {rdata[62:0], r};
        end
        i_sclk <= 1'b0;
        tick(6);
        i_cs_n <= 1'b1;
        i_sdio <= ~i_sdio;
        tick(6);
    endtask

    // Update pin pulse, then time for the outputs to follow
    task automatic upd();
        i_io_update <= 1'b1;
        tick(4);
        i_io_update <= 1'b0;
        tick(6);
    endtask

    task automatic wrap_up();
        $display("compared %0d, mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    initial begin
        tick(12);
        i_resetn <= 1'b1;
        tick(3);
        // Reset state of data-out enable, sync outputs and readback
        chk(o_sdo_oe, 1'b0);
        chk(o_sync, '0);
        for (int a = 9; a <= 13; a++) begin
            xfer({3'h4, a[4:0]}, 64'h0, (a == 11 || a == 12) ? 64 : 32, rd);
            chk(rd, 64'h0);
        end
        $display("test reset done");
        // Staged writes must not reach the amplitude or ramp limit outputs before an update
        oe_hits = 0;
        xfer({3'h0, ADDR_AMP}, {32'h0, wa}, 32, rd);
        xfer({3'h0, ADDR_LIM}, wl, 64, rd);
        xfer({3'h0, ADDR_STEP}, ws, 64, rd);
        xfer({3'h0, ADDR_RATE}, {32'h0, wr}, 32, rd);
        chk(oe_hits, 0);
        chk(o_amp, '0);
        chk(o_ramp[159:96], '0);
        // Data out enabled for every bit of a long read
        oe_hits = 0;
        xfer({3'h4, ADDR_LIM}, 64'h0, 64, rd);
        chk(oe_hits, 64);
        chk(rd, wl);
        xfer({3'h4, ADDR_RATE}, 64'h0, 32, rd);
        chk(rd, {32'h0, wr});
        upd();
        chk(o_amp, {wa[31:16], wa[15:2], wa[1:0]});
        chk(o_ramp.upper, wl[63:32]);
        chk(o_ramp.lower, wl[31:0]);
        chk(o_ramp.dec_step, ws[63:32]);
        chk(o_ramp.inc_step, ws[31:0]);
        chk({o_ramp.neg_rate, o_ramp.pos_rate}, wr);
        $display("test staged update done");
        // Sync fields, both polarities of every control bit
        for (int k = 0; k < 2; k++) begin
            xfer({3'h0, ADDR_SYNC}, {32'h0, wsy[k]}, 32, rd);
            xfer({3'h4, ADDR_SYNC}, 64'h0, 32, rd);
            chk(rd, {32'h0, wsy[k] & SYNC_WMASK});
            upd();
            chk(o_sync.valid_delay, wsy[k][31:28]);
            chk(o_sync.rx_enable, wsy[k][27]);
            chk(o_sync.gen_enable, wsy[k][26]);
            chk(o_sync.gen_falling, wsy[k][25]);
            chk(o_sync.preset, wsy[k][23:18]);
            chk(o_sync.out_delay, wsy[k][15:11]);
            chk(o_sync.in_delay, wsy[k][7:3]);
        end
        $display("test sync done");
        // Keying mode and ramp enable gates
        for (int m = 0; m < 4; m++) begin
            i_keying_mode <= m[1:0];
            tick(3);
            chk(o_amp, (m == 3) ? {wa[31:16], wa[15:2], wa[1:0]}
                                : {16'h0, wa[15:2], 2'h0});
        end
        i_ramp_enable <= 1'b0;
        tick(3);
        chk(o_ramp[159:96], '0);
        chk(o_ramp[95:0], '0);
        i_ramp_enable <= 1'b1;
        tick(3);
        chk(o_ramp.upper, wl[63:32]);
        $display("test gates done");
        // Unmapped address and aborted frame leave the registers alone
        xfer(8'h0e, {32'h0, 32'hffff_ffff}, 32, rd);
        xfer(8'h8e, 64'h0, 32, rd);
        chk(rd, 64'h0);
        xfer({3'h0, ADDR_AMP}, 64'hffff, 16, rd);
        xfer({3'h4, ADDR_AMP}, 64'h0, 32, rd);
        chk(rd, {32'h0, wa});
        upd();
        chk(o_amp, {wa[31:16], wa[15:2], wa[1:0]});
        $display("test refusals done");
        wrap_up();
    end
endmodule
